// ===== verilog/tsq_regs.svh
/*
  constants for the transitional store qualifier: widths, depth, tag share, clock period.
  assumes inclusion once per compilation unit via its guard.
*/
`ifndef TSQ_REGS_SVH
`define TSQ_REGS_SVH
`define TSQ_DATA_W 34
`define TSQ_TAG_W 32
`define TSQ_CHAN_DEPTH 4096
`define TSQ_TAG_SHARE 2
`define TSQ_CLK_PERIOD_NS 25
`endif

// ===== verilog/tsq_pkg.sv
/*
  types for the transitional store qualifier.
  assumes tsq_regs.svh supplies the numeric constants.
*/
package tsq_pkg;
  // storage policy state: was the previous sample a transition
  typedef enum logic [1:0] {
    TSQ_IDLE = 2'b00,
    TSQ_QUIET = 2'b01,
    TSQ_BURST = 2'b10
  } tsq_state_t;
endpackage

// ===== verilog/tsq_qualifier.sv
/*
  store qualifier for one pod pair in transitional timing acquisition.
  assumes probe inputs are asynchronous to clk, and that the trace memory
  beyond the write port accepts up to two writes per cycle with no back-pressure.
*/
`timescale 1ns/1ps
`include "tsq_regs.svh"

// Behaviour
// - sample every enabled clk, write only on the first sample of a run or when an enabled bit changes.
// - a transition stores all bits of the pod pair.
// - every stored sample gets a time tag beside it.
// - samples on internal clock; qualification from transition detector only.
// - half of per-channel memory holds tags, half holds data.
// - this pod pair keeps its own tag store and write pointer.
// - transition after quiet sample stores previous then current sample, or previous alone into the last slot.
// - transition after transition stores only the current sample.
// - quiet sample stores nothing; next transition stores two again.
// - a change on any enabled bit of the sample qualifies it.
// - disabled bits are stored but never cause storage.
// - first stored sample is a reference, not counted as transition.
module tsq_qualifier #(
  parameter int DATA_W = `TSQ_DATA_W,
  parameter int TAG_W = `TSQ_TAG_W,
  parameter int DEPTH = `TSQ_CHAN_DEPTH / `TSQ_TAG_SHARE,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic run,
  input wire logic [DATA_W-1:0] probe_in,
  input wire logic [DATA_W-1:0] bit_enable,
  input wire logic [AW-1:0] rd_addr,
  output logic [DATA_W-1:0] rd_data,
  output logic [TAG_W-1:0] rd_tag,
  output logic [AW:0] stored_count,
  output logic [AW:0] transition_count,
  output logic mem_full
);

  // ==========================================================
  // input synchroniser and sample pipeline
  logic [DATA_W-1:0] sync1_q;
  logic [DATA_W-1:0] sync2_q;
  logic [DATA_W-1:0] cur_q;
  logic [DATA_W-1:0] prev_q;
  logic [TAG_W-1:0] tag_now_q;
  logic [TAG_W-1:0] tag_prev_q;
  logic have_prev_q;
  tsq_pkg::tsq_state_t state_q;
  tsq_pkg::tsq_state_t state_d;
  logic [AW:0] wptr_q;
  logic [AW:0] tcount_q;
  logic [DATA_W-1:0] data_mem [DEPTH];
  logic [TAG_W-1:0] tag_mem [DEPTH];
  logic [DATA_W-1:0] rd_data_q;
  logic [TAG_W-1:0] rd_tag_q;

  // full when pointer reached the region size (both regions share it)
  wire full_w = (wptr_q == (AW+1)'(DEPTH));
  wire one_left_w = (wptr_q == (AW+1)'(DEPTH - 1));
  wire active_w = run && !full_w;
  // change on an enabled bit only
  wire trans_w = have_prev_q && |((sync2_q ^ cur_q) & bit_enable);
  // first sample of a run is stored as reference
  wire first_w = active_w && !have_prev_q && (state_q == tsq_pkg::TSQ_IDLE);
  wire two_w = active_w && trans_w && state_q != tsq_pkg::TSQ_BURST;
  wire one_w = active_w && trans_w && state_q == tsq_pkg::TSQ_BURST;
  // a two-sample store writes the prior and the current sample together,
  // so a transition right behind it still finds the write port free
  wire wr_prev_w = two_w;
  wire wr_cur_w = first_w || one_w || (two_w && !one_left_w);
  wire [AW:0] wptr_nx_w = wptr_q + (AW+1)'(1);

  // synchroniser: second stage alone feeds logic
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else if (ce) begin
      sync1_q <= probe_in;
      sync2_q <= sync1_q;
    end
  end

  // ==========================================================
  // policy state: burst after a transition, quiet otherwise, idle while run is low
  always_comb begin
    state_d = state_q;
    case (state_q)
      tsq_pkg::TSQ_IDLE: begin
        if (active_w) begin
          state_d = tsq_pkg::TSQ_QUIET;
        end
      end
      tsq_pkg::TSQ_QUIET: begin
        if (trans_w) begin
          state_d = tsq_pkg::TSQ_BURST;
        end
      end
      tsq_pkg::TSQ_BURST: begin
        if (!trans_w) begin
          state_d = tsq_pkg::TSQ_QUIET;
        end
      end
      default: begin
        state_d = tsq_pkg::TSQ_IDLE;
      end
    endcase
    if (!run) begin
      state_d = tsq_pkg::TSQ_IDLE;
    end
  end

  // sample every enabled cycle of a run on internal clock; tag counts sample periods
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cur_q <= '0;
      prev_q <= '0;
      tag_now_q <= '0;
      tag_prev_q <= '0;
      have_prev_q <= 1'b0;
      state_q <= tsq_pkg::TSQ_IDLE;
    end else if (ce) begin
      state_q <= state_d;
      if (run) begin
        prev_q <= cur_q;
        cur_q <= sync2_q;
        tag_prev_q <= tag_now_q;
        tag_now_q <= tag_now_q + TAG_W'(1);
        have_prev_q <= 1'b1;
      end else begin
        have_prev_q <= 1'b0;
        tag_now_q <= '0;
      end
    end
  end

  // ==========================================================
  // write port: data and own tag region share one pointer; a pair store
  // moves it by two, or by one when only one slot is left
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wptr_q <= '0;
      tcount_q <= '0;
    end else if (ce) begin
      if (!run) begin
        wptr_q <= '0;
        tcount_q <= '0;
      end else if (!full_w) begin
        if (wr_prev_w && wr_cur_w) begin
          wptr_q <= wptr_q + (AW+1)'(2);
        end else if (wr_prev_w || wr_cur_w) begin
          wptr_q <= wptr_nx_w;
        end
        if (two_w || one_w) begin
          tcount_q <= tcount_q + (AW+1)'(1);
        end
      end
    end
  end

  // storage arrays: full sample width with its tag
  always_ff @(posedge clk) begin
    if (ce && run && !full_w) begin
      if (wr_prev_w) begin
        data_mem[wptr_q[AW-1:0]] <= cur_q;
        tag_mem[wptr_q[AW-1:0]] <= tag_prev_q;
        // transition sample goes in the slot behind, if there is one
        if (wr_cur_w) begin
          data_mem[wptr_nx_w[AW-1:0]] <= sync2_q;
          tag_mem[wptr_nx_w[AW-1:0]] <= tag_now_q;
        end
      end else if (wr_cur_w) begin
        data_mem[wptr_q[AW-1:0]] <= sync2_q;
        tag_mem[wptr_q[AW-1:0]] <= tag_now_q;
      end
    end
  end

  // registered read port
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_data_q <= '0;
      rd_tag_q <= '0;
    end else if (ce) begin
      rd_data_q <= data_mem[rd_addr];
      rd_tag_q <= tag_mem[rd_addr];
    end
  end

  assign rd_data = rd_data_q;
  assign rd_tag = rd_tag_q;
  assign stored_count = wptr_q;
  assign transition_count = tcount_q;
  assign mem_full = full_w;

  // ==========================================================
  // assertions
  // pair store: prior and transition sample written in one cycle
  sequence s_pair_start;
    ce && two_w && !one_left_w;
  endsequence

  property p_quiet_no_store;
    @(posedge clk) disable iff (!rst_n)
    (ce && run && state_q == tsq_pkg::TSQ_BURST && !trans_w)
      |=> (wptr_q == $past(wptr_q));
  endproperty
  a_quiet_no_store: assert property (p_quiet_no_store)
    else $error("quiet sample stored");

  property p_two_samples;
    @(posedge clk) disable iff (!rst_n)
    s_pair_start |=> (wptr_q == $past(wptr_q) + (AW+1)'(2));
  endproperty
  a_two_samples: assert property (p_two_samples)
    else $error("two-store missed");

  property p_pair_data;
    @(posedge clk) disable iff (!rst_n)
    s_pair_start |=> (data_mem[$past(wptr_q[AW-1:0])] == $past(cur_q))
      && (data_mem[$past(wptr_nx_w[AW-1:0])] == $past(sync2_q));
  endproperty
  a_pair_data: assert property (p_pair_data)
    else $error("pair store data wrong");

  property p_one_sample;
    @(posedge clk) disable iff (!rst_n)
    (ce && one_w) |=> (wptr_q == $past(wptr_q) + (AW+1)'(1));
  endproperty
  a_one_sample: assert property (p_one_sample)
    else $error("burst store wrong");

  property p_full_stop;
    @(posedge clk) disable iff (!rst_n)
    (ce && run && full_w) |=> (wptr_q == $past(wptr_q));
  endproperty
  a_full_stop: assert property (p_full_stop)
    else $error("wrote past full");

  // a change on disabled bits alone must not move the write pointer
  property p_disabled_bits;
    @(posedge clk) disable iff (!rst_n)
    (ce && run && have_prev_q && ((sync2_q ^ cur_q) & bit_enable) == '0)
      |=> $stable(wptr_q);
  endproperty
  a_disabled_bits: assert property (p_disabled_bits)
    else $error("disabled bit qualified");

  property p_first_ref;
    @(posedge clk) disable iff (!rst_n)
    (ce && first_w) |=> (tcount_q == $past(tcount_q));
  endproperty
  a_first_ref: assert property (p_first_ref)
    else $error("reference counted");

  property p_tag_runs;
    @(posedge clk) disable iff (!rst_n)
    (ce && run) |=> (tag_now_q == $past(tag_now_q) + TAG_W'(1));
  endproperty
  a_tag_runs: assert property (p_tag_runs)
    else $error("tag not advancing");

  property p_trans_stores;
    @(posedge clk) disable iff (!rst_n)
    (ce && run && !full_w && trans_w) |=> (wptr_q != $past(wptr_q));
  endproperty
  a_trans_stores: assert property (p_trans_stores)
    else $error("transition lost");

endmodule

// ===== testbench/tsq_target.sv
/*
  model of the probed target signals feeding one pod pair.
  assumes the bench calls flip from its own process, in step with clk.
*/
`timescale 1ns/1ps

module tsq_target #(
  parameter int W = 34
) (
  input wire logic clk,
  output logic [W-1:0] pins
);
  // ==========================================================
  // pin drive
  // pins rest low until the bench asks for a change
  initial begin
    pins = '0;
  end

  // toggle the masked pins on n consecutive rising edges
  task automatic flip(input logic [W-1:0] m, input int n);
    repeat (n) begin
      @(posedge clk);
      pins <= pins ^ m;
    end
  endtask
endmodule

// ===== testbench/tsq_tb.sv
/*
  self-checking bench for the store qualifier with an 8-deep region.
  assumes tsq_regs.svh and tsq_target are compiled alongside.
*/
`timescale 1ns/1ps
`include "tsq_regs.svh"
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin n_errors++; \
  $display("Error %s expected %0h seen %0h", n, e, s); end end

module testbench;
  // ==========================================================
  // signals and instances
  localparam int DW = `TSQ_DATA_W;
  localparam int AW = 3;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic run = 1'b0;
  logic [DW-1:0] en = 34'h0_ffff_ffff;
  logic [DW-1:0] pins;
  logic [AW-1:0] rd_addr = '0;
  logic [DW-1:0] rd_data;
  logic [`TSQ_TAG_W-1:0] rd_tag;
  logic [AW:0] stored_count;
  logic [AW:0] transition_count;
  logic mem_full;
  int n_errors = 0;
  int n_tests = 0;

  tsq_target #(.W(DW)) tgt (.clk(clk), .pins(pins));

  tsq_qualifier #(.DEPTH(8)) DUT (
    .clk(clk), .rst_n(rst_n), .ce(ce), .run(run), .probe_in(pins),
    .bit_enable(en), .rd_addr(rd_addr), .rd_data(rd_data),
    .rd_tag(rd_tag), .stored_count(stored_count),
    .transition_count(transition_count), .mem_full(mem_full));

  // 40 MHz clock
  initial begin
    forever #12.5 clk = ~clk;
  end

  // ==========================================================
  // shared tasks
  // let a pin change run through the synchroniser and store pipeline
  task automatic settle;
    repeat (8) @(posedge clk);
    #1;
  endtask

  task automatic counts(input logic [AW:0] s, input logic [AW:0] t);
    `CHK("stored_count", s, stored_count)
    `CHK("transition_count", t, transition_count)
  endtask

  // registered read port: address then one cycle to the output
  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d,
                    output logic [`TSQ_TAG_W-1:0] t);
    @(posedge clk);
    rd_addr <= a;
    repeat (2) @(posedge clk);
    #1;
    d = rd_data;
    t = rd_tag;
  endtask

  task automatic restart;
    @(posedge clk);
    run <= 1'b0;
    @(posedge clk);
    run <= 1'b1;
    settle();
  endtask

  // ==========================================================
  // scenarios
  task automatic t_quiet;
    logic [DW-1:0] d0, d1, d2;
    logic [`TSQ_TAG_W-1:0] g0, g1, g2;
    restart();
    counts(4'h1, 4'h0);
    tgt.flip(34'h1, 1);
    settle();
    counts(4'h3, 4'h1);
    rd(3'h1, d1, g1);
    rd(3'h2, d2, g2);
    `CHK("prior sample", 34'h0, d1)
    `CHK("current sample", 34'h1, d2)
    `CHK("tag step", g1 + 32'h1, g2)
    rd(3'h0, d0, g0);
    `CHK("reference tag", 32'h0, g0)
    `CHK("reference data", 34'h0, d0)
  endtask

  task automatic t_disabled;
    logic [DW-1:0] d;
    logic [`TSQ_TAG_W-1:0] g;
    tgt.flip(34'h2_0000_0000, 1);
    settle();
    counts(4'h3, 4'h1);
    tgt.flip(34'h2, 1);
    settle();
    counts(4'h5, 4'h2);
    rd(3'h4, d, g);
    `CHK("all bits stored", 34'h2_0000_0003, d)
  endtask

  // clock enable low freezes sampling and storage
  task automatic t_freeze;
    @(posedge clk);
    ce <= 1'b0;
    tgt.flip(34'h1, 1);
    settle();
    counts(4'h5, 4'h2);
    @(posedge clk);
    ce <= 1'b1;
    settle();
    counts(4'h7, 4'h3);
  endtask

  task automatic t_burst_full;
    logic [DW-1:0] d;
    logic [`TSQ_TAG_W-1:0] g;
    restart();
    tgt.flip(34'h4, 3);
    settle();
    counts(4'h5, 4'h3);
    rd(3'h4, d, g);
    `CHK("burst last", 34'h2_0000_0006, d)
    tgt.flip(34'h4, 6);
    settle();
    counts(4'h8, 4'h5);
    `CHK("mem_full", 1'b1, mem_full)
    restart();
    counts(4'h1, 4'h0);
    `CHK("mem_full", 1'b0, mem_full)
  endtask

  // ==========================================================
  // verdict
  task automatic close_out;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_quiet();
    t_disabled();
    t_freeze();
    t_burst_full();
    close_out();
  end
endmodule
